//--- bench/ima_cpu_model.sv
/*
  Controller model: a classic Wishbone master for register traffic.
  Assumes callers start each transfer just after a rising clock edge.
*/
`timescale 1ns/1ps
module ima_cpu_model (
  input  wire         clk,
  input  wire         ack,
  output logic        cyc = 1'b0,
  output wire         stb,
  output logic        we = 1'b0,
  output logic [7:0]  adr = 8'h00,
  output logic [3:0]  sel = 4'h0,
  output logic [31:0] dat = 32'h0
);
  assign stb = cyc;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    // Released address and data lines change so the slave cannot lean on stale values.
    adr <= ~a;
    dat <= ~d;
    @(posedge clk);
  endtask
endmodule // ima_cpu_model

//--- bench/ima_monitor.sv
/*
  Port checker for the input module status block, bound at the foot of this file.
  Assumes the single clock, a one-cycle bus answer and a two-stage pin synchroniser.
*/
`timescale 1ns/1ps
module ima_monitor (
  input wire        CLK,
  input wire        SYS_RST,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_ACK_O,
  input wire        BP_SUPPLY_OK,
  input wire        LOAD_SUPPLY_OK,
  input wire [15:0] CH_IN,
  input wire        RUN_LED,
  input wire        ERR_LED,
  input wire        POWER_INDICATOR,
  input wire [15:0] CHANNEL_INDICATOR,
  input wire        HW_IRQ,
  input wire        DIAG_IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // Five samples cover the two-stage synchroniser and the output register.
  a_bp_dark: assert property (!BP_SUPPLY_OK [*5] |-> !RUN_LED && !ERR_LED)
    else $error("indicators lit without backplane");
  a_power_follows: assert property ($stable(LOAD_SUPPLY_OK) [*5] |-> POWER_INDICATOR == LOAD_SUPPLY_OK)
    else $error("power indicator wrong");
  a_chan_follows: assert property ($stable(CH_IN) [*5] |-> CHANNEL_INDICATOR == CH_IN)
    else $error("channel indicator wrong");
  a_err_run: assert property (BP_SUPPLY_OK [*5] ##0 ERR_LED |-> RUN_LED)
    else $error("error blink without run");
  // An acknowledge write lands at its ack edge, so the line may fall two cycles after release.
  a_hw_hold: assert property (HW_IRQ && !(WB_CYC_I || $past(WB_CYC_I)
    || $past(WB_CYC_I, 2)) |=> HW_IRQ)
    else $error("hardware interrupt dropped without ack");
  a_diag_hold: assert property (DIAG_IRQ && !(WB_CYC_I || $past(WB_CYC_I)
    || $past(WB_CYC_I, 2)) |=> DIAG_IRQ)
    else $error("diagnostic interrupt dropped without ack");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
endmodule // ima_monitor

bind ima_status_alarms ima_monitor mon_u (.CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .BP_SUPPLY_OK,
  .LOAD_SUPPLY_OK, .CH_IN, .RUN_LED, .ERR_LED, .POWER_INDICATOR, .CHANNEL_INDICATOR, .HW_IRQ, .DIAG_IRQ);

//--- bench/ima_status_alarms_bench.sv
/*
  Self-checking bench for the input module status block.
  Assumes the controller model owns the bus and this module drives the field pins.
*/
`timescale 1ns/1ps
module ima_status_alarms_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, hw, dg, run, err, power_ind;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rdat;
  logic        bp = 1'b0;
  logic        ld = 1'b1;
  logic [15:0] chi = 16'h0000;
  logic [15:0] wb = 16'h0000;
  logic [15:0] chl;
  logic [1:0]  cmp = 2'b00;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          kr, ke;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  always #10 clk = ~clk;

  ima_cpu_model cpu_u (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wd));
  ima_status_alarms #(.BLINK_HALF_CYC(24'd8)) dut_u (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .BP_SUPPLY_OK(bp), .LOAD_SUPPLY_OK(ld), .CH_IN(chi), .WIRE_BREAK(wb), .COMPARE_STATUS_BIT(cmp),
    .RUN_LED(run), .ERR_LED(err), .POWER_INDICATOR(power_ind), .CHANNEL_INDICATOR(chl), .HW_IRQ(hw), .DIAG_IRQ(dg));

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    cpu_u.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu_u.xfer(1'b1, a, d);
  endtask
  // Always lets one edge pass first, so a line that is still falling is not taken as a new one.
  task automatic irq(input bit d);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < 40 && (d ? dg : hw) !== 1'b1);
    chk(d ? dg : hw, 1, "interrupt line");
  endtask
  task automatic watch();
    kr = 0;
    ke = 0;
    repeat (20) begin
      @(posedge clk);
      kr += run;
      ke += err;
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      chk(rdat & msk_q.pop_front(), exp_q.pop_front(), "register read");
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h7d1200c0));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk({run, err}, 0, "lit without backplane");
    bp <= 1'b1;
    chi <= 16'($urandom());
    watch();
    chk(kr > 0 && kr < 20 && ke == 0, 1, "start-up blink");
    chk(chl, chi, "channel indicator");
    chi <= 16'h0000;
    repeat (4) @(posedge clk);
    wr(8'h04, 32'hffff_ffff);
    wr(8'h00, 32'h1);
    rd(8'h18, 32'h01, 32'h1f);
    rd(8'h1c, 32'h0, 32'hffff_ffff);
    watch();
    chk(kr == 20 && ke == 0, 1, "configured run");
    $display("test start-up done");
    for (int c = 0; c < 16; c++) begin
      for (int v = 1; v >= 0; v--) begin
        chi[c] <= v[0];
        irq(0);
        rd(8'h08, {16'h0001, 4'h0, c[3:0], v ? 8'h01 : 8'h02}, 32'hffff_0fff);
        wr(8'h0c, 32'h1);
      end
    end
    $display("test edges done");
    chi[2] <= 1'b1;
    irq(0);
    chi[3] <= 1'b1;
    irq(1);
    rd(8'h10, 32'h0003_1601, 32'h000f_ff0f);
    rd(8'h08, 32'h0001_0201, 32'hffff_0fff);
    wr(8'h0c, 32'h1);
    wr(8'h14, 32'h1);
    rd(8'h18, 32'h10, 32'h16);
    wr(8'h00, 32'h1);
    rd(8'h18, 32'h01, 32'h11);
    $display("test lost done");
    wb[5] <= 1'b1;
    irq(1);
    rd(8'h10, 32'h0005_0608, 32'h000f_ff0f);
    rd(8'h18, 32'hffdf_0000, 32'hffff_0000);
    watch();
    chk(kr == 20 && ke > 0 && ke < 20, 1, "error blink");
    wb[5] <= 1'b0;
    wr(8'h14, 32'h1);
    ld <= 1'b0;
    irq(1);
    rd(8'h10, 32'h0000_1104, 32'h000f_ff0f);
    chk(power_ind, 0, "power off");
    ld <= 1'b1;
    wr(8'h14, 32'h1);
    repeat (5) @(posedge clk);
    chk(power_ind, 1, "power on");
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h3);
    irq(1);
    rd(8'h10, 32'h0000_1002, 32'h000f_ff0f);
    rd(8'h18, 32'h08, 32'h09);
    watch();
    chk(kr > 0 && kr < 20 && ke > 0 && ke < 20, 1, "parameter error blink");
    wr(8'h14, 32'h1);
    $display("test diagnostics done");
    wr(8'h04, 32'hfffc_fffc);
    wr(8'h00, 32'h7);
    cmp <= 2'b01;
    irq(0);
    rd(8'h08, 32'h0001_0005, 32'hffff_0fff);
    wr(8'h0c, 32'h1);
    chi[0] <= 1'b1;
    cmp <= 2'b11;
    irq(0);
    rd(8'h08, 32'h0001_0105, 32'hffff_0fff);
    wr(8'h0c, 32'h1);
    $display("test compare done");
    finish_test();
  end
endmodule // ima_status_alarms_bench

//--- core/ima_defines.vh
/*
  Constants for the input module status, interrupt and alarm block.
  Assumes a 50 MHz module clock and a classic Wishbone slave port with word registers.
*/
// Function
// - Run and error indicators stay dark while backplane supply is absent.
// - Run indicator flashes at start-up until valid parameters are accepted, then steady.
// - Configured: run on, error flashes while any channel error is pending.
// - Power indicator lit while load supply is good, dark when missing.
// - Each channel indicator follows its input state, lit for one.
// - Diagnostic interrupt on load supply loss, wire break or parameter error.
// - Hardware interrupt on configured edges, and compare events in counting mode.
// - Each hardware interrupt supplies the triggering channel number.
// - Interrupt info starts with the two-byte structure identifier 0001.
// - Next comes one channel byte, 00 to 0F.
// - Then one event byte: 01 rising, 02 falling, 05 compare.
// - Every diagnostic event gives an alarm with error code, error indicator flashes; before a valid assignment the code flashes it for parameter errors only.
// - Wire break reports error code 06.
// - Unevaluable channel parameters report error code 10.
// - Missing load supply reports error code 11.
// - New hardware interrupt while one is unacknowledged is dropped, code 16 reported.
// - Interrupt-lost error stays latched until a new parameter assignment.
// - Load loss during pending wire break may briefly show wrong value status.
// - Compare interrupt fires on the rising edge of the compare status bit.
`ifndef IMA_DEFINES_VH
`define IMA_DEFINES_VH

`define IMA_ADR_CTRL      8'h00
`define IMA_ADR_PARAM     8'h04
`define IMA_ADR_HWINFO    8'h08
`define IMA_ADR_HWACK     8'h0c
`define IMA_ADR_DIAG      8'h10
`define IMA_ADR_DIAGACK   8'h14
`define IMA_ADR_STATUS    8'h18

`define IMA_CTRL_ASSIGN   0
`define IMA_CTRL_COUNT    1
`define IMA_CTRL_CMPEN    2
`define IMA_ACK_BIT       0

`define IMA_INFO_STRUCT_ID 16'h0001
`define IMA_EV_RISE       8'h01
`define IMA_EV_FALL       8'h02
`define IMA_EV_CMP        8'h05

`define IMA_ERR_NONE      8'h00
`define IMA_ERR_WIRE      8'h06
`define IMA_ERR_PARAM     8'h10
`define IMA_ERR_LOAD      8'h11
`define IMA_ERR_LOST      8'h16

`define IMA_CNT_CH_MASK   16'h0003
// Half blink period: 250 ms of the 50 MHz module clock, sized to the blink counter.
`define IMA_BLINK_HALF_CYC 24'hbebc20
`define IMA_BLINK_W       24

`endif

//--- core/ima_status_alarms.v
/*
  Status indicators, hardware and diagnostic interrupts and alarm codes of a 16-channel input module.
  Assumes filtered channel levels, wire-break flags, compare status bits and supply-good levels
  arrive asynchronously on pins, and that software reaches the registers over classic Wishbone.
*/
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "ima_defines.vh"

module ima_status_alarms #(
  parameter [`IMA_BLINK_W-1:0] BLINK_HALF_CYC = `IMA_BLINK_HALF_CYC
) (
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        BP_SUPPLY_OK,
  input  wire        LOAD_SUPPLY_OK,
  input  wire [15:0] CH_IN,
  input  wire [15:0] WIRE_BREAK,
  input  wire [1:0]  COMPARE_STATUS_BIT,
  output reg         RUN_LED,
  output reg         ERR_LED,
  output reg         POWER_INDICATOR,
  output reg  [15:0] CHANNEL_INDICATOR,
  output reg         HW_IRQ,
  output reg         DIAG_IRQ
);

  localparam SYNC_W = 36;

  function [3:0] lowest_index;
    input [15:0] vec;
    integer i;
    begin
      lowest_index = 4'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        if (vec[i]) begin
          lowest_index = i[3:0];
        end
      end
    end
  endfunction

  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer b;
    begin
      merge_bytes = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  reg [SYNC_W-1:0]           meta_ff;
  reg [SYNC_W-1:0]           sync_ff;
  reg [SYNC_W-1:0]           prev_ff;
  reg [`IMA_BLINK_W-1:0]     blink_cnt_ff;
  reg                        blink_ff;
  reg [15:0]                 rise_stage_ff;
  reg [15:0]                 fall_stage_ff;
  reg                        count_stage_ff;
  reg                        cmpen_stage_ff;
  reg [15:0]                 rise_en_ff;
  reg [15:0]                 fall_en_ff;
  reg                        count_mode_ff;
  reg                        cmp_en_ff;
  reg                        configured_ff;
  reg                        param_err_ff;
  reg                        lost_ff;
  reg                        hw_pend_ff;
  reg [3:0]                  hw_chan_ff;
  reg [7:0]                  hw_code_ff;
  reg                        diag_pend_ff;
  reg [7:0]                  diag_code_ff;
  reg [3:0]                  diag_chan_ff;

  wire        bp_s;
  wire        load_s;
  wire [1:0]  cmp_s;
  wire [15:0] wb_s;
  wire [15:0] ch_s;
  wire        bp_p;
  wire        load_p;
  wire [1:0]  cmp_p;
  wire [15:0] wb_p;
  wire [15:0] ch_p;

  assign {bp_s, load_s, cmp_s, wb_s, ch_s} = sync_ff;
  assign {bp_p, load_p, cmp_p, wb_p, ch_p} = prev_ff;

  // Bus access: ack one cycle after the request, the write acts at the edge the master sees ack.
  wire       wb_req   = WB_CYC_I & WB_STB_I;
  wire       wb_fire  = wb_req & WB_ACK_O;
  wire       wb_wr    = wb_fire & WB_WE_I;
  wire [7:0] wb_adr   = {WB_ADR_I[7:2], 2'b00};
  wire [31:0] ctrl_wr = merge_bytes({29'h0, cmpen_stage_ff, count_stage_ff, 1'b0}, WB_DAT_I, WB_SEL_I);
  wire [31:0] prm_wr  = merge_bytes({fall_stage_ff, rise_stage_ff}, WB_DAT_I, WB_SEL_I);
  wire       wr_ctrl  = wb_wr & (wb_adr == `IMA_ADR_CTRL);
  wire       wr_param = wb_wr & (wb_adr == `IMA_ADR_PARAM);
  wire       assign_p = wr_ctrl & WB_SEL_I[0] & WB_DAT_I[`IMA_CTRL_ASSIGN];
  wire       hw_ack   = wb_wr & (wb_adr == `IMA_ADR_HWACK) & WB_SEL_I[0] & WB_DAT_I[`IMA_ACK_BIT];
  wire       diag_ack = wb_wr & (wb_adr == `IMA_ADR_DIAGACK) & WB_SEL_I[0] & WB_DAT_I[`IMA_ACK_BIT];

  // Channels taken by the counters cannot also carry edge interrupts, so that set is refused.
  wire new_cnt   = ctrl_wr[`IMA_CTRL_COUNT];
  wire new_bad   = new_cnt & (|((rise_stage_ff | fall_stage_ff) & `IMA_CNT_CH_MASK));
  wire param_bad = assign_p & new_bad;

  wire [15:0] ch_mask = count_mode_ff ? ~`IMA_CNT_CH_MASK : 16'hffff;
  wire [15:0] rise_ev = ch_s & ~ch_p & rise_en_ff & ch_mask & {16{configured_ff}};
  wire [15:0] fall_ev = ~ch_s & ch_p & fall_en_ff & ch_mask & {16{configured_ff}};
  wire [1:0]  cmp_ev  = cmp_s & ~cmp_p & {2{count_mode_ff & cmp_en_ff & configured_ff}};
  wire [15:0] edge_ev = rise_ev | fall_ev;
  wire [15:0] all_ev  = edge_ev | {14'h0, cmp_ev};
  wire        any_ev  = |all_ev;
  wire [3:0]  ev_chan = lowest_index(all_ev);
  wire [15:0] ev_less = all_ev - 16'h0001;
  wire        ev_more = (|(all_ev & ev_less)) | (|(edge_ev & {14'h0, cmp_ev}));
  wire [7:0]  ev_code = rise_ev[ev_chan] ? `IMA_EV_RISE :
                        (fall_ev[ev_chan] ? `IMA_EV_FALL : `IMA_EV_CMP);
  wire        drop_ev = any_ev & ((hw_pend_ff & ~hw_ack) | ev_more);

  wire        load_loss = ~load_s & load_p;
  wire [15:0] wb_new    = wb_s & ~wb_p;
  wire        lost_new  = drop_ev & ~lost_ff;
  wire        diag_ev   = param_bad | load_loss | (|wb_new) | lost_new;
  // A channel with a pending wire break reads 0 in value_ok whether or not load supply drops.
  wire [15:0] value_ok  = ~wb_s & {16{load_s}};
  wire        err_any   = (|wb_s) | ~load_s | param_err_ff | lost_ff;

  reg [31:0] rd_data;

  always @* begin
    case (wb_adr)
      `IMA_ADR_CTRL:    rd_data = {29'h0, cmpen_stage_ff, count_stage_ff, 1'b0};
      `IMA_ADR_PARAM:   rd_data = {fall_stage_ff, rise_stage_ff};
      `IMA_ADR_HWINFO:  rd_data = {`IMA_INFO_STRUCT_ID, 4'h0, hw_chan_ff, hw_code_ff};
      `IMA_ADR_DIAG:    rd_data = {12'h0, diag_chan_ff, diag_code_ff, 4'h0, |wb_s, ~load_s, param_err_ff, lost_ff};
      `IMA_ADR_STATUS:  rd_data = {value_ok, 11'h0, lost_ff, param_err_ff, diag_pend_ff, hw_pend_ff, configured_ff};
      default:          rd_data = 32'h0;
    endcase
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      if (wb_req & ~WB_ACK_O) begin
        WB_DAT_O <= rd_data;
      end
    end
  end

  // Every pin passes two flip-flops; prev_ff keeps the last synchronised sample for edge detection.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_ff <= {SYNC_W{1'b0}};
      sync_ff <= {SYNC_W{1'b0}};
      prev_ff <= {SYNC_W{1'b0}};
    end else begin
      meta_ff <= {BP_SUPPLY_OK, LOAD_SUPPLY_OK, COMPARE_STATUS_BIT, WIRE_BREAK, CH_IN};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // One shared blink source keeps all flashing indicators in phase.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blink_cnt_ff <= {`IMA_BLINK_W{1'b0}};
      blink_ff     <= 1'b0;
    end else if (blink_cnt_ff == BLINK_HALF_CYC - 1'b1) begin
      blink_cnt_ff <= {`IMA_BLINK_W{1'b0}};
      blink_ff     <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end
  end

  // Writes only stage a set; the assign strobe commits it, so a half-written set never takes effect.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rise_stage_ff  <= 16'h0;
      fall_stage_ff  <= 16'h0;
      count_stage_ff <= 1'b0;
      cmpen_stage_ff <= 1'b0;
      rise_en_ff     <= 16'h0;
      fall_en_ff     <= 16'h0;
      count_mode_ff  <= 1'b0;
      cmp_en_ff      <= 1'b0;
      configured_ff  <= 1'b0;
      param_err_ff   <= 1'b0;
    end else begin
      if (wr_param) begin
        rise_stage_ff <= prm_wr[15:0];
        fall_stage_ff <= prm_wr[31:16];
      end
      if (wr_ctrl) begin
        count_stage_ff <= ctrl_wr[`IMA_CTRL_COUNT];
        cmpen_stage_ff <= ctrl_wr[`IMA_CTRL_CMPEN];
      end
      if (~bp_s) begin
        configured_ff <= 1'b0;
      end else if (assign_p) begin
        configured_ff <= ~new_bad;
        param_err_ff  <= new_bad;
        if (~new_bad) begin
          rise_en_ff    <= rise_stage_ff;
          fall_en_ff    <= fall_stage_ff;
          count_mode_ff <= new_cnt;
          cmp_en_ff     <= ctrl_wr[`IMA_CTRL_CMPEN];
        end
      end
    end
  end

  // Hardware interrupt: one capture held until acknowledged; an ack and a new event in one cycle keep the event.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hw_pend_ff <= 1'b0;
      hw_chan_ff <= 4'h0;
      hw_code_ff <= `IMA_ERR_NONE;
      lost_ff    <= 1'b0;
    end else begin
      if (any_ev & (~hw_pend_ff | hw_ack)) begin
        hw_pend_ff <= 1'b1;
        hw_chan_ff <= ev_chan;
        hw_code_ff <= ev_code;
      end else if (hw_ack) begin
        hw_pend_ff <= 1'b0;
      end
      if (drop_ev) begin
        lost_ff <= 1'b1;
      end else if (assign_p) begin
        lost_ff <= 1'b0;
      end
    end
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      diag_pend_ff <= 1'b0;
      diag_code_ff <= `IMA_ERR_NONE;
      diag_chan_ff <= 4'h0;
    end else begin
      if (diag_ev) begin
        diag_pend_ff <= 1'b1;
        if (param_bad) begin
          diag_code_ff <= `IMA_ERR_PARAM;
          diag_chan_ff <= 4'h0;
        end else if (load_loss) begin
          diag_code_ff <= `IMA_ERR_LOAD;
          diag_chan_ff <= 4'h0;
        end else if (|wb_new) begin
          diag_code_ff <= `IMA_ERR_WIRE;
          diag_chan_ff <= lowest_index(wb_new);
        end else begin
          diag_code_ff <= `IMA_ERR_LOST;
          diag_chan_ff <= ev_chan;
        end
      end else if (diag_ack) begin
        diag_pend_ff <= 1'b0;
      end
    end
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RUN_LED           <= 1'b0;
      ERR_LED           <= 1'b0;
      POWER_INDICATOR   <= 1'b0;
      CHANNEL_INDICATOR <= 16'h0;
      HW_IRQ            <= 1'b0;
      DIAG_IRQ          <= 1'b0;
    end else begin
      if (~bp_s) begin
        RUN_LED <= 1'b0;
        ERR_LED <= 1'b0;
      end else if (~configured_ff) begin
        // A refused assignment is a diagnostic event, so the error light flashes with the run light.
        RUN_LED <= blink_ff;
        ERR_LED <= param_err_ff & blink_ff;
      end else begin
        RUN_LED <= 1'b1;
        ERR_LED <= err_any & blink_ff;
      end
      POWER_INDICATOR   <= load_s;
      CHANNEL_INDICATOR <= ch_s;
      HW_IRQ            <= hw_pend_ff;
      DIAG_IRQ          <= diag_pend_ff;
    end
  end

endmodule // ima_status_alarms
